// *** verilog/qwic_top.sv ***
// Quad wiper I2C target: bus engine, settings, recall and write guard
`timescale 1ns/1ps
module qwic_top
   import qwic_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic address_select_bit_zero,
   input wire logic address_select_bit_one,
   input wire logic address_select_bit_two,
   input wire logic address_select_bit_three,
   input wire logic write_guard_n,
   output logic sda_out,
   output logic sda_oe,
   output logic [QW_DATA_W-1:0] wiper0_setting,
   output logic [QW_DATA_W-1:0] wiper1_setting,
   output logic [QW_DATA_W-1:0] wiper2_setting,
   output logic [QW_DATA_W-1:0] wiper3_setting
);
   // ==========================================================
   // Helper functions
   // Stored byte index from wiper and slot
   function automatic logic [QW_MEM_AW-1:0] qwic_index(input logic [QW_SEL_W-1:0] w,
                                                      input logic [QW_SEL_W-1:0] r);
      qwic_index = {w, r};
   endfunction

   // Saturating one-tap step
   function automatic logic [QW_DATA_W-1:0] qwic_step(input logic [QW_DATA_W-1:0] v,
                                                     input logic up);
      if (up)
         qwic_step = (v == QW_STEP_MAX) ? v : v + QW_STEP_ONE;
      else
         qwic_step = (v == QW_STEP_MIN) ? v : v - QW_STEP_ONE;
   endfunction

   // ==========================================================
   // Input synchronisers
   logic scl_s1_r, scl_s2_r, scl_d_r;   // Bus clock sync and delay
   logic sda_s1_r, sda_s2_r, sda_d_r;   // Bus data sync and delay
   logic [3:0] adr_s1_r, adr_s2_r;      // Address pin sync
   logic wg_s1_r, wg_s2_r;              // Guard pin sync

   // Two flops on every pin before use
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r <= 1'b1;
         adr_s1_r <= 4'h0;
         adr_s2_r <= 4'h0;
         wg_s1_r <= 1'b1;
         wg_s2_r <= 1'b1;
      end
      else if (clk_en)
      begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         scl_d_r <= scl_s2_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_d_r <= sda_s2_r;
         // Pin zero lands in the low bit
         adr_s1_r <= {address_select_bit_three, address_select_bit_two,
                      address_select_bit_one, address_select_bit_zero};
         adr_s2_r <= adr_s1_r;
         wg_s1_r <= write_guard_n;
         wg_s2_r <= wg_s1_r;
      end
   end

   // ==========================================================
   // Bus events, all derived from the sampled master clock and data lines
   logic scl_rise, scl_fall, bus_start, bus_stop;
   logic guard_ok;                               // Stored writes allowed
   assign scl_rise = scl_s2_r && !scl_d_r;
   assign scl_fall = !scl_s2_r && scl_d_r;
   assign bus_start = scl_s2_r && scl_d_r && !sda_s2_r && sda_d_r;
   assign bus_stop = scl_s2_r && scl_d_r && sda_s2_r && !sda_d_r;
   // Floating guard reads high through the board pull-up
   assign guard_ok = wg_s2_r;

   // ==========================================================
   // Engine registers
   qwic_state_t state_r;                 // Bus engine state
   qwic_kind_t kind_r;                   // Role of the byte in flight
   logic [QW_CNT_W-1:0] cnt_r;           // Bit counter
   logic [QW_DATA_W-1:0] sh_r;           // Receive shifter
   logic [QW_DATA_W-1:0] tx_r;           // Transmit shifter
   logic [QW_DATA_W-1:0] instr_r;        // Latched instruction
   logic tx_pend_r;                      // Next phase transmits
   logic sda_oe_r;                       // Pull-down enable
   logic rec_busy_r;                     // Power-up recall running
   logic [QW_CNT_W-1:0] rec_cnt_r;       // Recall step
   logic go1_r, go2_r;                   // Transfer pipeline
   logic [QW_DATA_W-1:0] wiper_r [QW_NUM_WIPERS]; // Settings
   logic [QW_DATA_W-1:0] mem_rdata;      // Stored byte read data

   // Decoded fields
   logic [3:0] op, new_op;
   logic [QW_SEL_W-1:0] wsel, rsel;
   assign op = instr_r[QW_OP_MSB:QW_OP_LSB];
   assign wsel = instr_r[QW_WSEL_MSB:QW_WSEL_LSB];
   assign rsel = instr_r[QW_RSEL_MSB:QW_RSEL_LSB];
   assign new_op = sh_r[QW_OP_MSB:QW_OP_LSB];

   // Completed received byte, seen on the falling edge after bit eight
   logic byte_done, data_done, op_valid, op_read, op_xfer;
   assign byte_done = (state_r == QW_RX) && scl_fall && (cnt_r == QW_BYTE_BITS);
   assign data_done = byte_done && (kind_r == QW_K_DATA);
   assign op_valid = (new_op == QW_OP_RD_WIPER) || (new_op == QW_OP_WR_WIPER) ||
                     (new_op == QW_OP_RD_STORE) || (new_op == QW_OP_WR_STORE) ||
                     (new_op == QW_OP_TO_WIPER) || (new_op == QW_OP_TO_STORE) ||
                     (new_op == QW_OP_INCDEC);
   assign op_read = (new_op == QW_OP_RD_WIPER) || (new_op == QW_OP_RD_STORE);
   assign op_xfer = (new_op == QW_OP_TO_WIPER) || (new_op == QW_OP_TO_STORE);

   // Acknowledge decision for the byte just received
   logic byte_ack;
   always_comb
   begin
      byte_ack = 1'b0;
      case (kind_r)
         QW_K_TARGET: byte_ack = (sh_r == {QW_FIXED_NIBBLE, adr_s2_r});
         QW_K_INSTR: byte_ack = op_valid;
         QW_K_DATA:
         begin
            if (op == QW_OP_WR_STORE)
               byte_ack = guard_ok;
            else
               byte_ack = (op == QW_OP_WR_WIPER) || (op == QW_OP_INCDEC);
         end
         default: byte_ack = 1'b0;
      endcase
   end

   // Byte to send: setting or stored byte
   logic [QW_DATA_W-1:0] tx_src;
   assign tx_src = (op == QW_OP_RD_STORE) ? mem_rdata : wiper_r[wsel];

   // ==========================================================
   // Bus engine; a start wins over all but recall so a stuck transfer can be restarted
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= QW_IDLE;
         kind_r <= QW_K_TARGET;
         cnt_r <= QW_CNT_ZERO;
         sh_r <= QW_WIPER_INIT;
         tx_r <= QW_WIPER_INIT;
         instr_r <= QW_WIPER_INIT;
         tx_pend_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (rec_busy_r)
         begin
            // Bus ignored until settings hold recalled values
            state_r <= QW_IDLE;
         end
         else if (bus_start)
         begin
            state_r <= QW_RX;
            kind_r <= QW_K_TARGET;
            cnt_r <= QW_CNT_ZERO;
            tx_pend_r <= 1'b0;
            sda_oe_r <= 1'b0;
         end
         else if (bus_stop)
         begin
            state_r <= QW_IDLE;
            sda_oe_r <= 1'b0;
         end
         else
         begin
            case (state_r)
               QW_RX:
               begin
                  if (scl_rise)
                  begin
                     sh_r <= {sh_r[QW_DATA_W-2:0], sda_s2_r};
                     cnt_r <= cnt_r + 1'b1;
                  end
                  else if (byte_done)
                  begin
                     if (byte_ack)
                     begin
                        sda_oe_r <= 1'b1;
                        state_r <= QW_ACK;
                     end
                     else
                     begin
                        // Not ours or refused: leave the line alone
                        state_r <= QW_IDLE;
                     end
                     if (kind_r == QW_K_INSTR)
                     begin
                        instr_r <= sh_r;
                        tx_pend_r <= op_read && byte_ack;
                     end
                     kind_r <= (kind_r == QW_K_TARGET) ? QW_K_INSTR : QW_K_DATA;
                  end
               end
               QW_ACK:
               begin
                  if (scl_fall)
                  begin
                     cnt_r <= QW_CNT_ZERO;
                     if (tx_pend_r)
                     begin
                        tx_r <= tx_src;
                        sda_oe_r <= !tx_src[QW_DATA_W-1];
                        state_r <= QW_TX;
                     end
                     else
                     begin
                        sda_oe_r <= 1'b0;
                        state_r <= QW_RX;
                     end
                  end
               end
               QW_TX:
               begin
                  if (scl_fall)
                  begin
                     if (cnt_r == QW_LAST_TX)
                     begin
                        sda_oe_r <= 1'b0; // Release for master answer
                        state_r <= QW_TXACK;
                     end
                     else
                     begin
                        cnt_r <= cnt_r + 1'b1;
                        tx_r <= {tx_r[QW_DATA_W-2:0], 1'b0};
                        sda_oe_r <= !tx_r[QW_DATA_W-2];
                     end
                  end
               end
               QW_TXACK:
               begin
                  if (scl_rise)
                  begin
                     // Master low means send again, high means done
                     tx_pend_r <= !sda_s2_r;
                     if (sda_s2_r)
                        state_r <= QW_IDLE;
                     else
                        state_r <= QW_ACK;
                  end
               end
               default: state_r <= QW_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // Transfer pipeline covers the stored byte read latency
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         go1_r <= 1'b0;
         go2_r <= 1'b0;
      end
      else if (clk_en)
      begin
         go1_r <= byte_done && (kind_r == QW_K_INSTR) && op_xfer && !rec_busy_r;
         go2_r <= go1_r;
      end
   end

   // ==========================================================
   // Power-up recall sequencer: even step addresses, odd step loads
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rec_busy_r <= 1'b1;
         rec_cnt_r <= QW_CNT_ZERO;
      end
      else if (clk_en && rec_busy_r)
      begin
         rec_cnt_r <= rec_cnt_r + 1'b1;
         rec_busy_r <= (rec_cnt_r != QW_REC_LAST);
      end
   end

   logic [QW_SEL_W-1:0] rec_w;
   assign rec_w = rec_cnt_r[QW_SEL_W:1];

   // ==========================================================
   // Stored byte memory ports
   logic mem_we;
   logic [QW_MEM_AW-1:0] mem_waddr, mem_raddr;
   logic [QW_DATA_W-1:0] mem_wdata;
   assign mem_raddr = rec_busy_r ? qwic_index(rec_w, QW_FIRST_SLOT) : qwic_index(wsel, rsel);
   // Guard gates every stored write path
   assign mem_we = guard_ok && ((data_done && (op == QW_OP_WR_STORE)) ||
                                (go2_r && (op == QW_OP_TO_STORE)));
   assign mem_waddr = qwic_index(wsel, rsel);
   assign mem_wdata = data_done ? sh_r : wiper_r[wsel];

   qwic_store_mem u_store
   (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(mem_raddr),
      .rd_data(mem_rdata)
   );

   // ==========================================================
   // Wiper settings; guard never blocks these
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < QW_NUM_WIPERS; i++)
         begin
            wiper_r[i] <= QW_WIPER_INIT;
         end
      end
      else if (clk_en)
      begin
         if (rec_busy_r && rec_cnt_r[0])
            wiper_r[rec_w] <= mem_rdata;
         else if (data_done && (op == QW_OP_WR_WIPER))
            wiper_r[wsel] <= sh_r;
         else if (data_done && (op == QW_OP_INCDEC))
            wiper_r[wsel] <= qwic_step(wiper_r[wsel], sh_r[QW_STEP_DIR_BIT]);
         else if (go2_r && (op == QW_OP_TO_WIPER))
            wiper_r[wsel] <= mem_rdata;
      end
   end

   // ==========================================================
   // Outputs; each setting code picks one tap only
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (clk_en)
      begin
         sda_out <= 1'b0;     // Only ever pulls low
         sda_oe <= sda_oe_r;
      end
   end
   assign wiper0_setting = wiper_r[0];
   assign wiper1_setting = wiper_r[1];
   assign wiper2_setting = wiper_r[2];
   assign wiper3_setting = wiper_r[3];
endmodule

// *** verilog/qwic_pkg.sv ***
// Shared constants and types for the quad wiper I2C control block
package qwic_pkg;
   // ==========================================================
   // Sizes
   localparam int QW_NUM_WIPERS = 4;              // Four wipers
   localparam int QW_NUM_STORED = 4;              // Stored settings per wiper
   localparam int QW_MEM_DEPTH = 16;              // Sixteen stored bytes
   localparam int QW_DATA_W = 8;                  // Setting width, 256 taps
   localparam int QW_MEM_AW = 4;                  // Stored byte address width
   localparam int QW_SEL_W = 2;                   // Wiper or slot select width
   localparam int QW_CNT_W = 4;                   // Bit counter width
   // ==========================================================
   // Reset and init values
   localparam logic [7:0] QW_STORE_INIT = 8'h80;  // Stored byte start value
   localparam logic [7:0] QW_WIPER_INIT = 8'h00;  // Setting before recall
   localparam logic [7:0] QW_STEP_MAX = 8'hFF;    // Top tap
   localparam logic [7:0] QW_STEP_MIN = 8'h00;    // Bottom tap
   localparam logic [7:0] QW_STEP_ONE = 8'h01;    // One tap step
   // Fixed upper nibble of the target byte; value is arbitrary
   localparam logic [3:0] QW_FIXED_NIBBLE = 4'h5;
   // ==========================================================
   // Counts and field positions
   localparam logic [3:0] QW_BYTE_BITS = 4'h8;    // Bits per byte
   localparam logic [3:0] QW_LAST_TX = 4'h7;      // Last transmit bit index
   localparam logic [3:0] QW_CNT_ZERO = 4'h0;     // Counter clear value
   localparam logic [3:0] QW_REC_LAST = 4'h7;     // Last recall step
   localparam int QW_OP_MSB = 7;                  // Opcode field high bit
   localparam int QW_OP_LSB = 4;                  // Opcode field low bit
   localparam int QW_WSEL_MSB = 3;                // Wiper field high bit
   localparam int QW_WSEL_LSB = 2;                // Wiper field low bit
   localparam int QW_RSEL_MSB = 1;                // Slot field high bit
   localparam int QW_RSEL_LSB = 0;                // Slot field low bit
   localparam int QW_STEP_DIR_BIT = 0;            // Data bit: 1 up, 0 down
   localparam logic [1:0] QW_FIRST_SLOT = 2'h0;   // Slot recalled at power-up
   // ==========================================================
   // Instruction opcodes
   localparam logic [3:0] QW_OP_RD_WIPER = 4'h9;  // Read a setting
   localparam logic [3:0] QW_OP_WR_WIPER = 4'hA;  // Write a setting
   localparam logic [3:0] QW_OP_RD_STORE = 4'hB;  // Read a stored byte
   localparam logic [3:0] QW_OP_WR_STORE = 4'hC;  // Write a stored byte
   localparam logic [3:0] QW_OP_TO_WIPER = 4'hD;  // Stored byte into setting
   localparam logic [3:0] QW_OP_TO_STORE = 4'hE;  // Setting into stored byte
   localparam logic [3:0] QW_OP_INCDEC = 4'h2;    // Step mode
   // ==========================================================
   // Bus engine states and byte roles
   typedef enum logic [2:0] {QW_IDLE, QW_RX, QW_ACK, QW_TX, QW_TXACK} qwic_state_t;
   typedef enum logic [1:0] {QW_K_TARGET, QW_K_INSTR, QW_K_DATA} qwic_kind_t;
endpackage

// *** verilog/qwic_store_mem.sv ***
// Sixteen byte stored-setting memory with registered read data
`timescale 1ns/1ps
module qwic_store_mem
   import qwic_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [QW_MEM_AW-1:0] wr_addr,
   input wire logic [QW_DATA_W-1:0] wr_data,
   input wire logic [QW_MEM_AW-1:0] rd_addr,
   output logic [QW_DATA_W-1:0] rd_data
);
   // ==========================================================
   // Storage
   logic [QW_DATA_W-1:0] mem_r [QW_MEM_DEPTH]; // Sixteen stored bytes

   // Write port; reset stands in for factory contents
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < QW_MEM_DEPTH; i++)
         begin
            mem_r[i] <= QW_STORE_INIT;
         end
      end
      else if (clk_en && wr_en)
      begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   // Registered read, one cycle latency
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_data <= QW_STORE_INIT;
      end
      else if (clk_en)
      begin
         rd_data <= mem_r[rd_addr];
      end
   end
endmodule

// *** bench/qwic_top_chk.sv ***
// Port checker for the quad wiper bus target
`timescale 1ns/1ps
module qwic_top_chk
   import qwic_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [QW_DATA_W-1:0] wiper0_setting,
   input wire logic [QW_DATA_W-1:0] wiper1_setting,
   input wire logic [QW_DATA_W-1:0] wiper2_setting,
   input wire logic [QW_DATA_W-1:0] wiper3_setting
);
   // ==========================================================
   // Helper counters
   logic scl_q_r; // Bus clock pin, one cycle late
   logic [3:0] since_fall_r; // Cycles since bus clock fell
   logic [3:0] hi_cnt_r; // Cycles bus clock stayed high
   logic [3:0] up_cnt_r; // Cycles since reset release
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Pin history for edge finding
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn) scl_q_r <= 1'b1;
      else scl_q_r <= scl_in;
   // Saturating age of the last bus clock fall
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn) since_fall_r <= 4'hF;
      else if (scl_q_r && !scl_in) since_fall_r <= 4'h0;
      else if (since_fall_r != 4'hF) since_fall_r <= since_fall_r + 4'h1;
   // Long high level means the bus is idle
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn) hi_cnt_r <= 4'h0;
      else if (!scl_in) hi_cnt_r <= 4'h0;
      else if (hi_cnt_r != 4'hF) hi_cnt_r <= hi_cnt_r + 4'h1;
   // Recall window is over once this saturates
   always_ff @(posedge sys_clk or negedge rstn)
      if (!rstn) up_cnt_r <= 4'h0;
      else if (up_cnt_r != 4'hF) up_cnt_r <= up_cnt_r + 4'h1;
   // ==========================================================
   // Assertions
   AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
      else $error("data line driven high");
   AST_PRE_RECALL: assert property ($rose(rstn) |-> wiper0_setting == QW_WIPER_INIT
      && wiper3_setting == QW_WIPER_INIT) else $error("setting not clear in reset");
   AST_RECALL_LOAD: assert property ($rose(rstn) |-> ##11 wiper0_setting == QW_STORE_INIT
      && wiper1_setting == QW_STORE_INIT && wiper2_setting == QW_STORE_INIT
      && wiper3_setting == QW_STORE_INIT) else $error("recall did not load settings");
   AST_QUIET_RECALL: assert property ($rose(rstn) |-> !sda_oe [*8])
      else $error("bus driven during recall");
   AST_WIPER_ON_BUS: assert property (up_cnt_r == 4'hF && ($changed(wiper0_setting)
      || $changed(wiper1_setting) || $changed(wiper2_setting) || $changed(wiper3_setting))
      |-> since_fall_r < 4'hB) else $error("setting changed without bus clock");
   AST_OE_RISE: assert property ($rose(sda_oe) |-> since_fall_r inside {[4'h2:4'h9]})
      else $error("data pulled low off the bus clock");
   AST_OE_FALL: assert property ($fell(sda_oe) |-> since_fall_r inside {[4'h2:4'h9]})
      else $error("data released off the bus clock");
   AST_OE_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*6])
      else $error("data low pulse too short");
   AST_IDLE_FREE: assert property (hi_cnt_r > 4'hB |-> !sda_oe)
      else $error("data held low on idle bus");
   // Main scenarios reached
   cover property ($rose(sda_oe));
   cover property (up_cnt_r == 4'hF && $changed(wiper0_setting));
   cover property ($rose(rstn) ##11 wiper2_setting == QW_STORE_INIT);
endmodule

// *** bench/qwic_bus_master.sv ***
// Bus master model that clocks and drives the wiper block's bus
`timescale 1ns/1ps
module qwic_bus_master
(
   input wire logic sys_clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_m
);
   // Idle: clock stands high, data released to the pull-up
   initial
   begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Quarter of a 160 ns bus clock period
   task q;
      repeat (2) @(posedge sys_clk);
   endtask
   // Data falls while clock is high
   task start;
      sda_m <= 1'b1;
      scl <= 1'b1;
      q;
      sda_m <= 1'b0;
      q;
      scl <= 1'b0;
   endtask
   // Data rises while clock is high
   task stop;
      q;
      sda_m <= 1'b0;
      q;
      scl <= 1'b1;
      q;
      sda_m <= 1'b1;
      q;
   endtask
   // One bit: data set in low phase, sampled mid high phase
   task bitx(input logic b, output logic r);
      q;
      sda_m <= b;
      q;
      scl <= 1'b1;
      q;
      @(negedge sys_clk) r = sda_in;
      q;
      scl <= 1'b0;
   endtask
   // Byte out MSB first, then the device's acknowledge
   task wr_byte(input logic [7:0] d, output bit ok);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, r);
      ok = (r === 1'b0);
   endtask
   // Byte in; last means no acknowledge from us
   task rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(last, r);
   endtask
endmodule

// *** bench/quad_wiper_i2c_control_tb_top.sv ***
// Self-checking bench for the quad wiper bus target
`timescale 1ns/1ps
module quad_wiper_i2c_control_tb_top;
   import qwic_pkg::*;
   logic sys_clk = 1'b0; // 50 MHz
   logic rstn = 1'b0; // Async reset
   logic clk_en = 1'b1; // Tied: freezing is not exercised
   logic [3:0] pins = 4'h0; // Address pins
   logic guard_n = 1'b1; // Write guard
   logic sda_out, sda_oe, scl, sda_m;
   logic [7:0] w0, w1, w2, w3, tgt;
   wire logic sda_w = sda_m & ~(sda_oe & ~sda_out);
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   integer seed = 32'h7e47d81d;
   int wip[4]; // Expected settings
   int sto[16]; // Expected stored bytes
   always #10 sys_clk = ~sys_clk;
   qwic_top i_dut(.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_w),
      .address_select_bit_zero(pins[0]), .address_select_bit_one(pins[1]),
      .address_select_bit_two(pins[2]), .address_select_bit_three(pins[3]),
      .write_guard_n(guard_n), .sda_out(sda_out), .sda_oe(sda_oe),
      .wiper0_setting(w0), .wiper1_setting(w1), .wiper2_setting(w2), .wiper3_setting(w3));
   qwic_bus_master i_mst(.sys_clk(sys_clk), .sda_in(sda_w), .scl(scl), .sda_m(sda_m));
   // Comparison and report
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard, well above the expected run
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 50000)
      begin
         err_total++;
         summarize;
      end
   end
   function logic [7:0] wv(input int k);
      return k == 0 ? w0 : k == 1 ? w1 : k == 2 ? w2 : w3;
   endfunction
   function logic [7:0] ins(input logic [3:0] op, input int w, input int s);
      return {op, 2'(w), 2'(s)};
   endfunction
   // One frame: target, instruction, optional data byte
   task cmd(input logic [7:0] t, input logic [7:0] op, input logic [7:0] d, input bit nd,
      output bit a0, output bit a1, output bit a2);
      a2 = 1'b0;
      i_mst.start();
      i_mst.wr_byte(t, a0);
      i_mst.wr_byte(op, a1);
      if (nd)
         i_mst.wr_byte(d, a2);
      i_mst.stop();
      @(negedge sys_clk);
   endtask
   // Read twice in one frame: an acknowledged read repeats
   task rdc(input logic [7:0] op, input logic [7:0] exp);
      logic [7:0] d;
      bit a0;
      bit a1;
      i_mst.start();
      i_mst.wr_byte(tgt, a0);
      i_mst.wr_byte(op, a1);
      i_mst.rd_byte(1'b0, d);
      chk(d, exp);
      i_mst.rd_byte(1'b1, d);
      chk(d, exp);
      i_mst.stop();
   endtask
   // Reset with fresh pins, then settings must hold slot zero
   task reset_recall;
      @(posedge sys_clk);
      rstn <= 1'b0;
      pins <= 4'($random(seed));
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (12) @(posedge sys_clk);
      tgt = {QW_FIXED_NIBBLE, pins};
      foreach (sto[n]) sto[n] = 8'h80;
      foreach (wip[k]) wip[k] = sto[k * 4];
      @(negedge sys_clk);
      for (int k = 0; k < 4; k++)
         chk(wv(k), 8'(wip[k]));
      $display("recall test finished");
   endtask
   initial
   begin
      logic [7:0] v;
      bit a0;
      bit a1;
      bit a2;
      reset_recall;
      // Foreign targets and an unknown opcode get no answer
      for (int k = 0; k < 5; k++)
      begin
         cmd(tgt ^ 8'(1 << k), ins(QW_OP_WR_WIPER, 0, 0), 8'h11, 1'b1, a0, a1, a2);
         chk({7'h0, a0}, 8'h00);
         chk(w0, 8'(wip[0]));
      end
      cmd(tgt, 8'h00, 8'h00, 1'b0, a0, a1, a2);
      chk({6'h0, a0, a1}, 8'h02);
      $display("address test finished");
      // Each setting written alone, others unchanged
      for (int k = 0; k < 4; k++)
      begin
         v = 8'($random(seed));
         cmd(tgt, ins(QW_OP_WR_WIPER, k, 0), v, 1'b1, a0, a1, a2);
         wip[k] = v;
         chk({5'h0, a0, a1, a2}, 8'h07);
         for (int j = 0; j < 4; j++)
            chk(wv(j), 8'(wip[j]));
         rdc(ins(QW_OP_RD_WIPER, k, 0), 8'(wip[k]));
      end
      $display("setting test finished");
      // All sixteen stored bytes, guard high
      for (int n = 0; n < 16; n++)
      begin
         v = 8'($random(seed));
         cmd(tgt, ins(QW_OP_WR_STORE, n / 4, n % 4), v, 1'b1, a0, a1, a2);
         sto[n] = v;
         chk({6'h0, a1, a2}, 8'h03);
      end
      for (int n = 0; n < 16; n++)
         rdc(ins(QW_OP_RD_STORE, n / 4, n % 4), 8'(sto[n]));
      $display("stored test finished");
      // Guard low: stored writes refused, settings still free
      @(posedge sys_clk);
      guard_n <= 1'b0;
      cmd(tgt, ins(QW_OP_WR_STORE, 1, 1), ~8'(sto[5]), 1'b1, a0, a1, a2);
      chk({6'h0, a1, a2}, 8'h02);
      rdc(ins(QW_OP_RD_STORE, 1, 1), 8'(sto[5]));
      v = 8'($random(seed));
      cmd(tgt, ins(QW_OP_WR_WIPER, 2, 0), v, 1'b1, a0, a1, a2);
      wip[2] = v;
      chk(w2, v);
      cmd(tgt, ins(QW_OP_TO_STORE, 2, 3), 8'h00, 1'b0, a0, a1, a2);
      chk({7'h0, a1}, 8'h01);
      rdc(ins(QW_OP_RD_STORE, 2, 3), 8'(sto[11]));
      $display("guard test finished");
      // Transfers both ways with guard high
      @(posedge sys_clk);
      guard_n <= 1'b1;
      cmd(tgt, ins(QW_OP_TO_STORE, 1, 3), 8'h00, 1'b0, a0, a1, a2);
      sto[7] = wip[1];
      rdc(ins(QW_OP_RD_STORE, 1, 3), 8'(sto[7]));
      cmd(tgt, ins(QW_OP_TO_WIPER, 3, 2), 8'h00, 1'b0, a0, a1, a2);
      wip[3] = sto[14];
      chk(w3, 8'(wip[3]));
      // Steps saturate at both ends
      for (int i = 0; i < 2; i++)
      begin
         wip[0] = i ? 1 : 254;
         cmd(tgt, ins(QW_OP_WR_WIPER, 0, 0), 8'(wip[0]), 1'b1, a0, a1, a2);
         repeat (2)
         begin
            cmd(tgt, ins(QW_OP_INCDEC, 0, 0), i ? 8'h00 : 8'h01, 1'b1, a0, a1, a2);
            wip[0] = i ? (wip[0] > 0 ? wip[0] - 1 : 0) : (wip[0] < 255 ? wip[0] + 1 : 255);
            chk(w0, 8'(wip[0]));
         end
      end
      $display("transfer test finished");
      reset_recall;
      summarize;
   end
endmodule
bind qwic_top qwic_top_chk i_chk(.sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .wiper0_setting(wiper0_setting), .wiper1_setting(wiper1_setting),
   .wiper2_setting(wiper2_setting), .wiper3_setting(wiper3_setting));
